//--- design/sbpm_regs.svh
// Constants for the strap latch and Bluetooth pad mux.
// Assumes a 100 MHz core clock and a power-on reset on nrst.
`ifndef SBPM_REGS_SVH
`define SBPM_REGS_SVH
`define SBPM_CLK_PERIOD_NS 10
`define SBPM_STRAP_DELAY_US 2000
`define SBPM_STRAP_DELAY_CYC \
   ((`SBPM_STRAP_DELAY_US * 1000) / `SBPM_CLK_PERIOD_NS)
`define SBPM_SDIO_VOLT_PULL 1'b1
`define SBPM_HOST_IF_PULL 1'b0
`define SBPM_FUNC_DEFAULT 4'h0
`define SBPM_NUM_PADS 17
`endif

//--- design/sbpm_pkg.sv
// Types for the strap latch and Bluetooth pad mux.
// Assumes nothing beyond the constant header.
package sbpm_pkg;
   typedef logic [3:0] sbpm_func_t;
   typedef enum logic [1:0] {SBPM_WAIT, SBPM_SAMPLE, SBPM_DONE} sbpm_state_t;
   // Pad index order used by the pad function setting bus
   typedef enum int {
      SBPM_CTS = 0, SBPM_RTS, SBPM_RXD, SBPM_TXD,
      SBPM_PIN, SBPM_POUT, SBPM_PSYNC, SBPM_PCLK,
      SBPM_IDO, SBPM_IDI, SBPM_IWS, SBPM_ICLK,
      SBPM_G5, SBPM_G4, SBPM_G3, SBPM_G2, SBPM_CREQ
   } sbpm_pad_t;
endpackage

//--- design/sbpm_strap.sv
// Strap sampler: waits after reset, captures straps, then releases pads.
// Assumes the pad drives its pull level onto strap inputs while sampling.
`timescale 1ns/1ps
`include "sbpm_regs.svh"
module sbpm_strap
   import sbpm_pkg::*;
#(
   parameter int DELAY_CYC = `SBPM_STRAP_DELAY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Strap pins
   input wire logic sdio_volt_pin,
   input wire logic host_if_pin,
   // Results
   output logic sdio_1v8_reg,
   output logic host_sdio_reg,
   output logic sampling_reg,
   output logic done_reg
);
   sbpm_state_t state_reg;
   logic [31:0] count_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SBPM_WAIT;
         count_reg <= 32'h0;
      end else begin
         case (state_reg)
            SBPM_WAIT: begin
               count_reg <= count_reg + 32'h1;
               if (count_reg == 32'(DELAY_CYC - 1)) begin
                  state_reg <= SBPM_SAMPLE; // RQ1
               end
            end
            SBPM_SAMPLE: state_reg <= SBPM_DONE;
            SBPM_DONE: state_reg <= SBPM_DONE; // RQ21
            default: state_reg <= SBPM_WAIT;
         endcase
      end
   end

   // Pulls are on for the whole wait so the straps settle before capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sampling_reg <= 1'b1; // RQ3
         done_reg <= 1'b0;
      end else begin
         sampling_reg <= (state_reg != SBPM_SAMPLE) && !done_reg;
         done_reg <= done_reg || (state_reg == SBPM_SAMPLE); // RQ2
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sdio_1v8_reg <= `SBPM_SDIO_VOLT_PULL; // RQ4
         host_sdio_reg <= `SBPM_HOST_IF_PULL; // RQ5
      end else if (state_reg == SBPM_SAMPLE) begin
         sdio_1v8_reg <= sdio_volt_pin; // RQ1
         host_sdio_reg <= host_if_pin; // RQ5
      end
   end

   a_capture_once: assert property (@(posedge clk) disable iff (!nrst)
      done_reg && $past(done_reg) |-> $stable(host_sdio_reg)
         && $stable(sdio_1v8_reg)) // RQ21
      else $error("strap value changed after capture");
   a_done_follows: assert property (@(posedge clk) disable iff (!nrst)
      state_reg == SBPM_SAMPLE |=> done_reg && !sampling_reg) // RQ2
      else $error("pads not released after sampling");
   a_pull_during: assert property (@(posedge clk) disable iff (!nrst)
      !done_reg |-> sampling_reg || state_reg == SBPM_DONE) // RQ3
      else $error("pull dropped before capture");
   c_strap_done: cover property (@(posedge clk) disable iff (!nrst)
      $rose(done_reg));
endmodule // sbpm_strap

//--- design/sbpm_pad.sv
// One muxed pad: selects output, drive enable and input routing.
// Assumes the parent supplies per-function data and enables.
`timescale 1ns/1ps
module sbpm_pad
   import sbpm_pkg::*;
(
   // Selection
   input wire sbpm_func_t func,
   input wire logic [15:0] fn_out,
   input wire logic [15:0] fn_oe,
   // Pad result
   output logic pad_out,
   output logic pad_oe,
   output logic [15:0] fn_sel
);
   // Unlisted settings leave the pad undriven; fn_sel still flags the setting and GPIO inputs still read the pad,
   // except UART pads and, while a UART pad is at setting 7, the pad sharing its GPIO
   always_comb begin
      fn_sel = 16'h0;
      fn_sel[func] = 1'b1; // RQ6
      pad_out = fn_out[func];
      pad_oe = fn_oe[func];
   end
endmodule // sbpm_pad

//--- design/sbpm_top.sv
// Strap latch and Bluetooth multiplexed pad router.
// Assumes software holds pad settings stable and pins are synchronous.
// Operation
// (RQ1) Sample straps once, delay after reset
// (RQ2) Release strap pins to normal role afterward
// (RQ3) Internal pull applied during strap sampling
// (RQ4) SDIO voltage strap pulls 1; 1=1.8V
// (RQ5) Host strap pulls 0 PCIe; board pulls high
// (RQ6) Each pad uses only its own setting
// (RQ7) Setting 0 makes pad plain GPIO; UART pads and the clock request pad are not GPIO at 0
// (RQ8) UART pads: UART at 0, GPIO at 7
// (RQ9) PCM pads map PCM, I2S, flash, GPIO
// (RQ10) I2S pads map PCM, I2S, status, grant
// (RQ11) GPIO pads 2-5 map I2S, clock request
// (RQ12) Clock request pad: request 0, GPIO 7
// (RQ13) PCM sync/clock output only as master
// (RQ14) Audio clocks driven only in master mode
// (RQ15) Partner drives transmit grant input
// (RQ16) Radio busy high during local slots
// (RQ17) Status output shows Bluetooth priority
// (RQ18) Flash mode: drive clock, data, select
// (RQ19) Clock request output asks reference clock
// (RQ20) Link indicator shows link activity
// (RQ21) Captured straps held until next reset
`timescale 1ns/1ps
`include "sbpm_regs.svh"
module sbpm_top
   import sbpm_pkg::*;
#(
   parameter int STRAP_DELAY_CYC = `SBPM_STRAP_DELAY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Strap pins
   input wire logic sdio_volt_pin_in,
   output logic sdio_volt_pin_pull_reg,
   input wire logic host_if_pin_in,
   output logic host_if_pin_pull_reg,
   output logic strap_pull_en_reg,
   output logic strap_done_reg,
   output logic sdio_1v8_reg,
   output logic host_sdio_reg,
   // Pad settings, four bits per pad
   input wire logic [67:0] pad_func,
   input wire logic pcm_master,
   // Muxed pads
   input wire logic [16:0] bluetooth_muxed_pad_in,
   output logic [16:0] bluetooth_muxed_pad_out_reg,
   output logic [16:0] bluetooth_muxed_pad_oe_reg,
   // General purpose I/O
   input wire logic [7:0] gpio_out,
   input wire logic [7:0] gpio_oe,
   output logic [7:0] gpio_in_reg,
   input wire logic [7:0] agpio_out,
   input wire logic [7:0] agpio_oe,
   output logic [7:0] agpio_in_reg,
   // UART
   input wire logic uart_rts_n,
   input wire logic uart_txd,
   output logic uart_cts_n_reg,
   output logic uart_rxd_reg,
   // PCM
   input wire logic pcm_out,
   input wire logic pcm_sync_out,
   input wire logic pcm_clk_out,
   output logic pcm_in_reg,
   output logic pcm_sync_in_reg,
   output logic pcm_clk_in_reg,
   // Audio serial
   input wire logic audio_master_data_out,
   input wire logic audio_master_word_select,
   input wire logic audio_master_bit_clock,
   input wire logic audio_slave_data_out,
   output logic audio_slave_bit_clock_reg,
   output logic audio_slave_word_select_reg,
   output logic audio_data_in_reg,
   // Coexistence and misc
   input wire logic bt_slot_active,
   input wire logic bt_priority,
   input wire logic link_activity,
   input wire logic clock_request,
   input wire logic host_clock,
   output logic coex_radio_busy_reg,
   output logic coex_transmit_grant_reg,
   output logic host_clock_in_reg,
   // Serial flash
   input wire logic flash_serial_clock,
   input wire logic flash_data_out,
   input wire logic flash_select_n,
   output logic flash_data_in_reg
);
   logic sampling;
   logic done;
   logic [16:0] p_out;
   logic [16:0] p_oe;
   logic [15:0] sel [17];
   logic [15:0] fo [17];
   logic [15:0] fe [17];
   logic [16:0] pin;

   assign pin = bluetooth_muxed_pad_in;

   sbpm_strap #(.DELAY_CYC(STRAP_DELAY_CYC)) u_strap (
      .clk(clk),
      .nrst(nrst),
      .sdio_volt_pin(sdio_volt_pin_in),
      .host_if_pin(host_if_pin_in),
      .sdio_1v8_reg(sdio_1v8_reg),
      .host_sdio_reg(host_sdio_reg),
      .sampling_reg(sampling),
      .done_reg(done)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_pull_en_reg <= 1'b1;
         strap_done_reg <= 1'b0;
         sdio_volt_pin_pull_reg <= `SBPM_SDIO_VOLT_PULL;
         host_if_pin_pull_reg <= `SBPM_HOST_IF_PULL;
      end else begin
         strap_pull_en_reg <= sampling; // RQ3
         strap_done_reg <= done; // RQ2
         sdio_volt_pin_pull_reg <= `SBPM_SDIO_VOLT_PULL; // RQ4
         host_if_pin_pull_reg <= `SBPM_HOST_IF_PULL; // RQ5
      end
   end

   // One-hot masks of functions that drive; setting index is the bit
   function automatic logic [15:0] bit_at(input int n, input logic v);
      logic [15:0] r;
      r = 16'h0;
      r[n] = v;
      return r;
   endfunction

   always_comb begin
      for (int i = 0; i < 17; i++) begin
         fo[i] = 16'h0;
         fe[i] = 16'h0;
      end
      // UART pads
      fo[SBPM_CTS] = bit_at(7, agpio_out[1]); // RQ8
      fe[SBPM_CTS] = bit_at(7, agpio_oe[1]);
      fo[SBPM_RTS] = bit_at(0, uart_rts_n) | bit_at(7, agpio_out[0]);
      fe[SBPM_RTS] = bit_at(0, 1'b1) | bit_at(7, agpio_oe[0]);
      fo[SBPM_RXD] = bit_at(7, gpio_out[5]);
      fe[SBPM_RXD] = bit_at(7, gpio_oe[5]);
      fo[SBPM_TXD] = bit_at(0, uart_txd) | bit_at(7, gpio_out[4]);
      fe[SBPM_TXD] = bit_at(0, 1'b1) | bit_at(7, gpio_oe[4]);
      // PCM pads
      fo[SBPM_PIN] = bit_at(0, agpio_out[3]) | bit_at(15, 1'b0); // RQ9
      fe[SBPM_PIN] = bit_at(0, agpio_oe[3]);
      fo[SBPM_POUT] = bit_at(0, agpio_out[2]) | bit_at(1, pcm_out)
         | bit_at(2, pcm_out) | bit_at(3, link_activity) // RQ20
         | bit_at(5, audio_master_data_out) | bit_at(7, audio_slave_data_out)
         | bit_at(15, flash_data_out); // RQ18
      fe[SBPM_POUT] = bit_at(0, agpio_oe[2]) | 16'h80AE;
      fo[SBPM_PSYNC] = bit_at(0, agpio_out[1]) | bit_at(1, pcm_sync_out)
         | bit_at(2, pcm_sync_out) | bit_at(5, audio_master_word_select)
         | bit_at(15, flash_select_n); // RQ18
      fe[SBPM_PSYNC] = bit_at(0, agpio_oe[1]) | bit_at(1, pcm_master)
         | bit_at(2, pcm_master) | bit_at(5, 1'b1) // RQ13
         | bit_at(15, 1'b1);
      fo[SBPM_PCLK] = bit_at(0, agpio_out[0]) | bit_at(1, pcm_clk_out)
         | bit_at(2, pcm_clk_out) | bit_at(5, audio_master_bit_clock)
         | bit_at(15, flash_serial_clock);
      fe[SBPM_PCLK] = bit_at(0, agpio_oe[0]) | bit_at(1, pcm_master)
         | bit_at(2, pcm_master) | bit_at(5, 1'b1) // RQ14
         | bit_at(15, 1'b1);
      // I2S pads
      fo[SBPM_IDO] = bit_at(0, agpio_out[5]) | bit_at(1, pcm_out) // RQ10
         | bit_at(4, audio_slave_data_out) | bit_at(5, audio_master_data_out)
         | bit_at(7, bt_priority); // RQ17
      fe[SBPM_IDO] = bit_at(0, agpio_oe[5]) | 16'h00B2;
      fo[SBPM_IDI] = bit_at(0, agpio_out[6]);
      fe[SBPM_IDI] = bit_at(0, agpio_oe[6]);
      fo[SBPM_IWS] = bit_at(0, gpio_out[7]) | bit_at(1, pcm_sync_out)
         | bit_at(3, link_activity) | bit_at(5, audio_master_word_select);
      fe[SBPM_IWS] = bit_at(0, gpio_oe[7]) | bit_at(1, pcm_master)
         | bit_at(3, 1'b1) | bit_at(5, 1'b1);
      fo[SBPM_ICLK] = bit_at(0, gpio_out[6]) | bit_at(1, pcm_clk_out)
         | bit_at(5, audio_master_bit_clock);
      fe[SBPM_ICLK] = bit_at(0, gpio_oe[6]) | bit_at(1, pcm_master)
         | bit_at(5, 1'b1);
      // Bluetooth GPIO pads 5..2
      fo[SBPM_G5] = bit_at(0, gpio_out[5]) | bit_at(3, audio_master_bit_clock)
         | bit_at(7, clock_request); // RQ11
      fe[SBPM_G5] = bit_at(0, gpio_oe[5]) | 16'h0088;
      fo[SBPM_G4] = bit_at(0, gpio_out[4]) | bit_at(1, link_activity)
         | bit_at(3, audio_master_data_out) | bit_at(4, audio_slave_data_out);
      fe[SBPM_G4] = bit_at(0, gpio_oe[4]) | 16'h001A;
      fo[SBPM_G3] = bit_at(0, gpio_out[3]) | bit_at(3, audio_master_word_select);
      fe[SBPM_G3] = bit_at(0, gpio_oe[3]) | 16'h0008;
      fo[SBPM_G2] = bit_at(0, gpio_out[2]); // RQ7
      fe[SBPM_G2] = bit_at(0, gpio_oe[2]);
      // Clock request pad
      fo[SBPM_CREQ] = bit_at(0, clock_request) // RQ19
         | bit_at(7, agpio_out[7]);
      fe[SBPM_CREQ] = bit_at(0, 1'b1) | bit_at(7, agpio_oe[7]); // RQ12
   end

   genvar g;
   generate
      for (g = 0; g < `SBPM_NUM_PADS; g++) begin : g_pad
         sbpm_pad u_pad (
            .func(pad_func[4*g +: 4]), // RQ6
            .fn_out(fo[g]),
            .fn_oe(fe[g]),
            .pad_out(p_out[g]),
            .pad_oe(p_oe[g]),
            .fn_sel(sel[g])
         );
      end
   endgenerate

   // Strap pins are released only after capture; muxed pads stay passive
   // while straps sample so board pulls are not fought
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bluetooth_muxed_pad_out_reg <= 17'h0;
         bluetooth_muxed_pad_oe_reg <= 17'h0;
      end else begin
         bluetooth_muxed_pad_out_reg <= p_out;
         bluetooth_muxed_pad_oe_reg <= done ? p_oe : 17'h0; // RQ2
      end
   end

   // Input routing; a peripheral function not selected anywhere reads idle, GPIO inputs read pads, but gpio_in_reg[1:0] and agpio_in_reg[4] read 0
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gpio_in_reg <= 8'h0;
         agpio_in_reg <= 8'h0;
         uart_cts_n_reg <= 1'b1;
         uart_rxd_reg <= 1'b1;
         pcm_in_reg <= 1'b0;
         pcm_sync_in_reg <= 1'b0;
         pcm_clk_in_reg <= 1'b0;
         audio_slave_bit_clock_reg <= 1'b0;
         audio_slave_word_select_reg <= 1'b0;
         audio_data_in_reg <= 1'b0;
         coex_transmit_grant_reg <= 1'b0;
         host_clock_in_reg <= 1'b0;
         flash_data_in_reg <= 1'b0;
      end else begin
         gpio_in_reg <= {pin[SBPM_IWS], pin[SBPM_ICLK],
            sel[SBPM_RXD][7] ? pin[SBPM_RXD] : pin[SBPM_G5],
            sel[SBPM_TXD][7] ? pin[SBPM_TXD] : pin[SBPM_G4],
            pin[SBPM_G3], pin[SBPM_G2], 2'b00};
         agpio_in_reg <= {pin[SBPM_CREQ], pin[SBPM_IDI], pin[SBPM_IDO],
            1'b0, pin[SBPM_PIN], pin[SBPM_POUT],
            sel[SBPM_CTS][7] ? pin[SBPM_CTS] : pin[SBPM_PSYNC],
            sel[SBPM_RTS][7] ? pin[SBPM_RTS] : pin[SBPM_PCLK]};
         uart_cts_n_reg <= sel[SBPM_CTS][0] ? pin[SBPM_CTS] : 1'b1; // RQ8
         uart_rxd_reg <= sel[SBPM_RXD][0] ? pin[SBPM_RXD] : 1'b1;
         pcm_in_reg <= (sel[SBPM_PIN][1] | sel[SBPM_PIN][2]) & pin[SBPM_PIN]
            | sel[SBPM_IDI][1] & pin[SBPM_IDI];
         pcm_sync_in_reg <= !pcm_master & (sel[SBPM_PSYNC][1]
            | sel[SBPM_PSYNC][2]) & pin[SBPM_PSYNC]; // RQ13
         pcm_clk_in_reg <= !pcm_master & (sel[SBPM_PCLK][1]
            | sel[SBPM_PCLK][2]) & pin[SBPM_PCLK];
         audio_slave_bit_clock_reg <= sel[SBPM_PCLK][7] & pin[SBPM_PCLK]
            | sel[SBPM_ICLK][7] & pin[SBPM_ICLK]
            | sel[SBPM_G5][4] & pin[SBPM_G5]; // RQ14
         audio_slave_word_select_reg <= sel[SBPM_PSYNC][7] & pin[SBPM_PSYNC]
            | sel[SBPM_IWS][7] & pin[SBPM_IWS]
            | sel[SBPM_G3][4] & pin[SBPM_G3];
         audio_data_in_reg <= sel[SBPM_PIN][7] & pin[SBPM_PIN]
            | sel[SBPM_IDI][4] & pin[SBPM_IDI]
            | sel[SBPM_G2][4] & pin[SBPM_G2];
         coex_transmit_grant_reg <= sel[SBPM_IDI][7] & pin[SBPM_IDI]; // RQ15
         host_clock_in_reg <= sel[SBPM_PIN][3] & pin[SBPM_PIN]
            | sel[SBPM_PSYNC][3] & pin[SBPM_PSYNC]
            | sel[SBPM_IDI][3] & pin[SBPM_IDI] | sel[SBPM_G5][1] & host_clock;
         flash_data_in_reg <= sel[SBPM_PIN][15] & pin[SBPM_PIN];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         coex_radio_busy_reg <= 1'b0;
      end else begin
         coex_radio_busy_reg <= bt_slot_active; // RQ16
      end
   end

   a_busy_follows: assert property (@(posedge clk) disable iff (!nrst)
      bt_slot_active |=> coex_radio_busy_reg) // RQ16
      else $error("radio busy low during slot");
   a_gpio_zero: assert property (@(posedge clk) disable iff (!nrst)
      done && pad_func[4*SBPM_G2 +: 4] == 4'h0
      |=> bluetooth_muxed_pad_oe_reg[SBPM_G2] == $past(gpio_oe[2])) // RQ7
      else $error("pad at setting 0 not plain GPIO");
   a_pcm_slave: assert property (@(posedge clk) disable iff (!nrst)
      !pcm_master && pad_func[4*SBPM_PCLK +: 4] == 4'h1
      |=> !bluetooth_muxed_pad_oe_reg[SBPM_PCLK]) // RQ13
      else $error("PCM clock driven as slave");
   a_flash_sel: assert property (@(posedge clk) disable iff (!nrst)
      done && pad_func[4*SBPM_PSYNC +: 4] == 4'hF
      |=> bluetooth_muxed_pad_oe_reg[SBPM_PSYNC]
         && bluetooth_muxed_pad_out_reg[SBPM_PSYNC]
            == $past(flash_select_n)) // RQ18
      else $error("flash select not driven");
   a_creq_out: assert property (@(posedge clk) disable iff (!nrst)
      done && pad_func[4*SBPM_G5 +: 4] == 4'h7
      |=> bluetooth_muxed_pad_out_reg[SBPM_G5] == $past(clock_request)) // RQ11
      else $error("clock request not on pad 5");
   a_no_drive: assert property (@(posedge clk) disable iff (!nrst)
      !done |=> bluetooth_muxed_pad_oe_reg == 17'h0) // RQ2
      else $error("pad driven before strap release");
   c_flash: cover property (@(posedge clk) disable iff (!nrst)
      done && pad_func[4*SBPM_PIN +: 4] == 4'hF);
   c_i2s_slave: cover property (@(posedge clk) disable iff (!nrst)
      done && pad_func[4*SBPM_PCLK +: 4] == 4'h7);
   c_grant: cover property (@(posedge clk) disable iff (!nrst)
      $rose(coex_transmit_grant_reg));
endmodule // sbpm_top

//--- bench/sbpm_board.sv
// Board model: strap resistors and peripherals on the muxed pads.
// Assumes the bench sets strap drive and peripheral values.
`timescale 1ns/1ps
module sbpm_board (
   // Clock
   input wire logic clk,
   // Device side
   input wire logic pull_en,
   input wire logic sdio_pull,
   input wire logic host_pull,
   input wire logic [16:0] pad_out,
   input wire logic [16:0] pad_oe,
   // Bench control
   input wire logic brd_en,
   input wire logic brd_sdio,
   input wire logic brd_host,
   input wire logic [16:0] ext_en,
   input wire logic [16:0] ext_val,
   // Pin levels
   output logic sdio_pin,
   output logic host_pin,
   output logic [16:0] pad_wire
);
   // Undriven lines have no pull, so they wander instead of settling
   logic tog = 1'b0;
   always @(posedge clk) begin
      tog <= ~tog;
   end
   // A board resistor overrides the weak internal pull
   assign sdio_pin = brd_en ? brd_sdio : (pull_en ? sdio_pull : tog);
   assign host_pin = brd_en ? brd_host : (pull_en ? host_pull : tog);
   // Peripherals drive inputs, slave clocks and the grant
   always_comb begin
      for (int i = 0; i < 17; i++) begin
         pad_wire[i] = pad_oe[i] ? pad_out[i] :
            (ext_en[i] ? ext_val[i] : tog ^ i[0]);
      end
   end
endmodule // sbpm_board

//--- bench/tb_strap_latch_and_bt_pad_mux.sv
// Testbench for the strap latch and pad mux, with a reference pad table.
// Assumes sbpm_top, sbpm_pkg and the board model are compiled first.
`timescale 1ns/1ps
module tb_strap_latch_and_bt_pad_mux;
   localparam int DLY = 10;
   logic clk, nrst, sdio_volt_pin_in, host_if_pin_in, brd_en, brd_sdio;
   logic sdio_volt_pin_pull_reg, host_if_pin_pull_reg, strap_pull_en_reg;
   logic strap_done_reg, sdio_1v8_reg, host_sdio_reg, brd_host, exp_sd;
   logic [67:0] pad_func;
   logic [16:0] bluetooth_muxed_pad_in, bluetooth_muxed_pad_out_reg;
   logic [16:0] bluetooth_muxed_pad_oe_reg, ext_en, ext_val;
   logic [7:0] gpio_out, gpio_oe, gpio_in_reg, agpio_out, agpio_oe;
   logic [7:0] agpio_in_reg;
   logic pcm_master, uart_rts_n, uart_txd, uart_cts_n_reg, uart_rxd_reg;
   logic pcm_out, pcm_sync_out, pcm_clk_out, pcm_in_reg, pcm_sync_in_reg;
   logic pcm_clk_in_reg, audio_master_data_out, audio_master_word_select;
   logic audio_master_bit_clock, audio_slave_data_out, exp_hs;
   logic audio_slave_bit_clock_reg, audio_slave_word_select_reg;
   logic audio_data_in_reg, bt_slot_active, bt_priority, link_activity;
   logic clock_request, host_clock, coex_radio_busy_reg, host_clock_in_reg;
   logic coex_transmit_grant_reg, flash_serial_clock, flash_data_out;
   logic flash_select_n, flash_data_in_reg;
   logic [3:0] fsel [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h7, 4'hF};
   int err_total, tests_run;

   sbpm_top #(.STRAP_DELAY_CYC(DLY)) i_sbpm_top (
      .clk, .nrst, .sdio_volt_pin_in, .sdio_volt_pin_pull_reg,
      .host_if_pin_in, .host_if_pin_pull_reg, .strap_pull_en_reg,
      .strap_done_reg, .sdio_1v8_reg, .host_sdio_reg, .pad_func, .pcm_master,
      .bluetooth_muxed_pad_in, .bluetooth_muxed_pad_out_reg,
      .bluetooth_muxed_pad_oe_reg, .gpio_out, .gpio_oe, .gpio_in_reg,
      .agpio_out, .agpio_oe, .agpio_in_reg, .uart_rts_n, .uart_txd,
      .uart_cts_n_reg, .uart_rxd_reg, .pcm_out, .pcm_sync_out, .pcm_clk_out,
      .pcm_in_reg, .pcm_sync_in_reg, .pcm_clk_in_reg, .audio_master_data_out,
      .audio_master_word_select, .audio_master_bit_clock,
      .audio_slave_data_out, .audio_slave_bit_clock_reg,
      .audio_slave_word_select_reg, .audio_data_in_reg, .bt_slot_active,
      .bt_priority, .link_activity, .clock_request, .host_clock,
      .coex_radio_busy_reg, .coex_transmit_grant_reg, .host_clock_in_reg,
      .flash_serial_clock, .flash_data_out, .flash_select_n,
      .flash_data_in_reg
   );

   sbpm_board i_sbpm_board (
      .clk, .pull_en(strap_pull_en_reg), .sdio_pull(sdio_volt_pin_pull_reg),
      .host_pull(host_if_pin_pull_reg), .pad_out(bluetooth_muxed_pad_out_reg),
      .pad_oe(bluetooth_muxed_pad_oe_reg), .brd_en, .brd_sdio, .brd_host,
      .ext_en, .ext_val, .sdio_pin(sdio_volt_pin_in),
      .host_pin(host_if_pin_in), .pad_wire(bluetooth_muxed_pad_in)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask

   task automatic give_verdict();
      $display("Checks run %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic fs(int p, logic [3:0] f);
      return pad_func[4*p +: 4] == f;
   endfunction

   // Reference pad table: {drive enable, drive value} per pad and setting
   function automatic logic [1:0] drv(int p, logic [3:0] f);
      logic [1:0] pm;
      logic [1:0] pc;
      pm = {pcm_master, pcm_sync_out};
      pc = {pcm_master, pcm_clk_out};
      case (p * 16 + f)
         7: return {agpio_oe[1], agpio_out[1]};
         16: return {1'b1, uart_rts_n};
         23, 112: return {agpio_oe[0], agpio_out[0]};
         39, 192: return {gpio_oe[5], gpio_out[5]};
         48: return {1'b1, uart_txd};
         55, 208: return {gpio_oe[4], gpio_out[4]};
         64: return {agpio_oe[3], agpio_out[3]};
         80: return {agpio_oe[2], agpio_out[2]};
         81, 82, 129: return {1'b1, pcm_out};
         83, 163, 209: return {1'b1, link_activity};
         85, 133, 211: return {1'b1, audio_master_data_out};
         87, 132, 212: return {1'b1, audio_slave_data_out};
         95: return {1'b1, flash_data_out};
         96: return {agpio_oe[1], agpio_out[1]};
         97, 98, 161: return pm;
         101, 165, 227: return {1'b1, audio_master_word_select};
         111: return {1'b1, flash_select_n};
         113, 114, 177: return pc;
         117, 181, 195: return {1'b1, audio_master_bit_clock};
         127: return {1'b1, flash_serial_clock};
         128: return {agpio_oe[5], agpio_out[5]};
         135: return {1'b1, bt_priority};
         144: return {agpio_oe[6], agpio_out[6]};
         160: return {gpio_oe[7], gpio_out[7]};
         176: return {gpio_oe[6], gpio_out[6]};
         199, 256: return {1'b1, clock_request};
         224: return {gpio_oe[3], gpio_out[3]};
         240: return {gpio_oe[2], gpio_out[2]};
         263: return {agpio_oe[7], agpio_out[7]};
         default: return 2'b00;
      endcase
   endfunction

   task automatic rnd();
      {gpio_out, gpio_oe, agpio_out, agpio_oe} = $urandom;
      {pcm_master, uart_rts_n, uart_txd, pcm_out, pcm_sync_out, pcm_clk_out,
         audio_master_data_out, audio_master_word_select,
         audio_master_bit_clock, audio_slave_data_out, bt_slot_active,
         bt_priority, link_activity, clock_request, host_clock,
         flash_serial_clock, flash_data_out, flash_select_n} = 18'($urandom);
      ext_val = 17'($urandom);
      for (int i = 0; i < 17; i++) begin
         pad_func[4*i +: 4] = fsel[$urandom % 9];
      end
   endtask

   task automatic strap_run(logic en, logic sd, logic hs);
      int n;
      nrst = 1'b0;
      brd_en = en;
      brd_sdio = sd;
      brd_host = hs;
      ext_en = '0;
      exp_sd = en ? sd : 1'b1;
      exp_hs = en ? hs : 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      n = 0;
      while (strap_done_reg !== 1'b1 && n < 100) begin
         check(bluetooth_muxed_pad_oe_reg, 17'h0);
         if (n < DLY) check(strap_pull_en_reg, 1'b1);
         @(negedge clk);
         n++;
      end
      check(n >= DLY && n <= DLY + 4, 1'b1);
      check(strap_pull_en_reg, 1'b0);
      check({sdio_volt_pin_pull_reg, host_if_pin_pull_reg}, 2'b10);
      check(sdio_1v8_reg, exp_sd);
      check(host_sdio_reg, exp_hs);
      brd_en = 1'b1;
      brd_sdio = ~exp_sd;
      brd_host = ~exp_hs;
      repeat (5) @(negedge clk);
      check({sdio_1v8_reg, host_sdio_reg}, {exp_sd, exp_hs});
      ext_en = 17'h1FFFF;
      $display("strap test done: sdio %0h host %0h", exp_sd, exp_hs);
   endtask

   task automatic mux_run(int iters);
      logic [1:0] e;
      logic [16:0] p;
      for (int k = 0; k < iters; k++) begin
         rnd();
         repeat (2) @(negedge clk);
         for (int i = 0; i < 17; i++) begin
            e = drv(i, pad_func[4*i +: 4]);
            check(bluetooth_muxed_pad_oe_reg[i], e[1]);
            if (e[1]) check(bluetooth_muxed_pad_out_reg[i], e[0]);
         end
         check(uart_cts_n_reg, fs(0, 4'h0) ? ext_val[0] : 1'b1);
         check(uart_rxd_reg, fs(2, 4'h0) ? ext_val[2] : 1'b1);
         check(coex_transmit_grant_reg, fs(9, 4'h7) & ext_val[9]);
         check(flash_data_in_reg, fs(4, 4'hF) & ext_val[4]);
         check(coex_radio_busy_reg, bt_slot_active);
         p = bluetooth_muxed_pad_in;
         check(gpio_in_reg, {p[10], p[11],
            fs(2, 4'h7) ? p[2] : p[12], fs(3, 4'h7) ? p[3] : p[13],
            p[14], p[15], 2'b00});
         check(agpio_in_reg, {p[16], p[9], p[8], 1'b0, p[4], p[5],
            fs(0, 4'h7) ? p[0] : p[6], fs(1, 4'h7) ? p[1] : p[7]});
         check(pcm_in_reg,
            (fs(4, 4'h1) | fs(4, 4'h2)) & p[4] | fs(9, 4'h1) & p[9]);
         check({pcm_sync_in_reg, pcm_clk_in_reg}, {2{!pcm_master}}
            & {(fs(6, 4'h1) | fs(6, 4'h2)) & p[6],
            (fs(7, 4'h1) | fs(7, 4'h2)) & p[7]});
         check(audio_slave_bit_clock_reg, fs(7, 4'h7) & p[7]
            | fs(11, 4'h7) & p[11] | fs(12, 4'h4) & p[12]);
         check(audio_slave_word_select_reg, fs(6, 4'h7) & p[6]
            | fs(10, 4'h7) & p[10] | fs(14, 4'h4) & p[14]);
         check(audio_data_in_reg, fs(4, 4'h7) & p[4]
            | fs(9, 4'h4) & p[9] | fs(15, 4'h4) & p[15]);
         check(host_clock_in_reg, fs(4, 4'h3) & p[4]
            | fs(6, 4'h3) & p[6] | fs(9, 4'h3) & p[9]
            | fs(12, 4'h1) & host_clock);
      end
      check({sdio_1v8_reg, host_sdio_reg}, {exp_sd, exp_hs});
      $display("mux test done: %0d settings", iters);
   endtask

   initial begin
      err_total = 0;
      tests_run = 0;
      void'($urandom(82299));
      rnd();
      strap_run(1'b0, 1'b0, 1'b0);
      mux_run(200);
      strap_run(1'b1, 1'b0, 1'b1);
      mux_run(200);
      give_verdict();
   end

   // Whole run needs under 1000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule // tb_strap_latch_and_bt_pad_mux
